// File: hdl/omrc_pkg.sv
package omrc_pkg;
    // ************************************************
    // register map (plain port, byte-wide data)
    // ************************************************
    localparam logic [3:0] OMRC_SYSCTL_ADDR = 4'h0;
    localparam logic [3:0] OMRC_INTCTL_ADDR = 4'h1;
    localparam logic [3:0] OMRC_STATUS_ADDR = 4'h2;
    localparam logic [3:0] OMRC_RSTSRC_ADDR = 4'h3;
    // system control bits
    localparam int OMRC_FAST_OSC_EN_BIT = 7;
    localparam int OMRC_SLOW_OSC_EN_BIT = 6;
    localparam int OMRC_CLK_SEL_BIT = 5;
    localparam int OMRC_HALT_REQ_BIT = 2;
    localparam int OMRC_CPU_HALT_BIT = 4;
    // interrupt control bits
    localparam int OMRC_MIE_BIT = 0;
    localparam int OMRC_L8EN_BIT = 1;
    localparam int OMRC_TBEN_BIT = 2;
    localparam int OMRC_L8SEL_BIT = 3;
    localparam int OMRC_TBLATCH_BIT = 4;
    // reset values
    localparam logic [7:0] OMRC_SYSCTL_RST = 8'h80;
    localparam logic [7:0] OMRC_INTCTL_RST = 8'h00;
    localparam logic [15:0] OMRC_RESET_VECTOR_ADDR = 16'hfffe;
    // timing
    localparam int OMRC_CLK_HZ = 25000000;
    localparam int OMRC_RST_HOLD_FC = 24;
    localparam int OMRC_RST_CNT_W = 5;
    localparam int OMRC_SYNC_STAGES = 2;

    typedef enum logic [2:0]
    {
        OMRC_FAST_SINGLE = 3'b000,
        OMRC_FAST_DUAL = 3'b001,
        OMRC_SLOW_OSC_ON = 3'b011,
        OMRC_SLOW_OSC_OFF = 3'b010,
        OMRC_TB_HALT = 3'b110,
        OMRC_CPU_HALT = 3'b111,
        OMRC_CLK_SYNC = 3'b101
    } omrc_mode_t;
endpackage

// File: hdl/omrc_rst_stretch.sv
`timescale 1ns/10ps
// ************************************************
// internal reset request stretcher
// ************************************************
module omrc_rst_stretch
#(
    parameter int HOLD = 24,
    parameter int CW = 5
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    output logic active_o
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic active_r;
    logic active_nxt;

    initial
    begin
        if (HOLD < 1 || HOLD >= (1 << CW))
            $error("hold count does not fit counter");
    end

    // a held request keeps reloading, so reset lasts until it ends
    always_comb
    begin
        cnt_nxt = cnt_r;
        active_nxt = active_r;
        if (req_i)
        begin
            cnt_nxt = CW'(HOLD - 1);
            active_nxt = 1'b1;
        end
        else if (cnt_r != '0)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
        else
        begin
            active_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            active_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            active_r <= active_nxt;
        end
    end

    assign active_o = active_r;
endmodule

// File: hdl/omrc_top.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - all three enables set: timebase edge ends halt, then timebase interrupt serviced.
// - halt ends on next timebase falling edge, returning to prior mode.
// - watchdog interrupt just before cpu halt: service it, skip halt.
// - level-8 select at 1: resume after halt instruction, no interrupt.
// - clock select 1 switches system clock to low frequency.
// - clearing fast oscillator enable in slow mode stops it and goes oscillator-off.
// - reset pin low in slow mode resets at once; fast single afterwards.
// - after clock select cleared, run on slow clock until clocks synchronised.
// - four reset sources: pin, address trap, watchdog, system clock.
// - internal reset request holds reset 24 fast clocks after it ends.
// - internal reset circuits uninitialised at power-up; up to 24 clocks. Here the pin reset clears the stretcher, so no extra hold follows.
// - internal reset never drives reset pin low.
// - reset clears master enable, individual enables, interrupt latches.
// - reset clears prescaler and divider; watchdog stays enabled.
// - stack pointer, registers, flags and ram not initialised.
// - after reset, fetch vector from top two addresses.
// - disabling selected oscillator, or both, raises system clock reset.
// - leaving timebase halt clears halt request and restores previous mode.
module omrc_top
import omrc_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic TB_SRC_CLK_I,
    input wire logic ADDR_TRAP_REQ_I,
    input wire logic WDT_RESET_REQ_I,
    input wire logic WDT_INT_I,
    input wire logic FAST_CLK_SYNCED_I,
    input wire logic INT_ACK_I,
    output logic CORE_RESET_N_O,
    output logic RESET_PIN_DRIVE_N_O,
    output logic FAST_OSC_EN_O,
    output logic SLOW_OSC_EN_O,
    output logic SYS_CLK_SLOW_O,
    output logic CPU_HALT_O,
    output logic PERIPH_HALT_O,
    output logic TB_INT_REQ_O,
    output logic WDT_INT_SERVICE_O,
    output logic PRESCALER_CLR_O,
    output logic WDT_ENABLE_O,
    output logic [15:0] VECTOR_ADDR_O,
    output logic VECTOR_FETCH_O,
    output logic [2:0] MODE_O
);
    import omrc_pkg::*;

    // ************************************************
    // register and mode state
    // ************************************************
    logic [7:0] sysctl_r, sysctl_nxt;
    logic mie_r, mie_nxt;
    logic l8en_r, l8en_nxt;
    logic tben_r, tben_nxt;
    logic l8sel_r, l8sel_nxt;
    logic tblatch_r, tblatch_nxt;
    omrc_mode_t mode_r, mode_nxt;
    omrc_mode_t ret_mode_r, ret_mode_nxt;
    logic [7:0] rdata_nxt;
    logic [2:0] rst_src_r, rst_src_nxt;
    logic tb_q1_r, tb_q2_r, tb_q3_r;
    logic clk_rst_req_r, clk_rst_req_nxt;
    logic stretch_active;
    logic core_rst_n_nxt;
    logic vec_fetch_nxt;
    logic wdt_svc_nxt;
    logic tb_fall;
    logic wake_with_int;
    function automatic logic is_slow(input omrc_mode_t m);
        is_slow = (m == OMRC_SLOW_OSC_ON) || (m == OMRC_SLOW_OSC_OFF);
    endfunction
    // ************************************************
    // timebase edge detection
    // ************************************************
    // first stage is read only by the second; edge taken from stages 2/3
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tb_q1_r <= 1'b1;
            tb_q2_r <= 1'b1;
            tb_q3_r <= 1'b1;
        end
        else
        begin
            tb_q1_r <= TB_SRC_CLK_I;
            tb_q2_r <= tb_q1_r;
            tb_q3_r <= tb_q2_r;
        end
    end

    assign tb_fall = tb_q3_r & ~tb_q2_r;
    // level-8 select steers the line to another source, so no interrupt
    assign wake_with_int = mie_r & l8en_r & tben_r & ~l8sel_r;

    // ************************************************
    // internal reset requests
    // ************************************************
    omrc_rst_stretch
    #(
        .HOLD(OMRC_RST_HOLD_FC),
        .CW(OMRC_RST_CNT_W)
    )
    u_stretch
    (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I),
        .req_i(ADDR_TRAP_REQ_I | WDT_RESET_REQ_I | clk_rst_req_r),
        .active_o(stretch_active)
    );

    // ************************************************
    // next-state logic
    // ************************************************
    always_comb
    begin
        sysctl_nxt = sysctl_r;
        mie_nxt = mie_r;
        l8en_nxt = l8en_r;
        tben_nxt = tben_r;
        l8sel_nxt = l8sel_r;
        tblatch_nxt = tblatch_r;
        mode_nxt = mode_r;
        ret_mode_nxt = ret_mode_r;
        rdata_nxt = 8'h00;
        rst_src_nxt = rst_src_r;
        clk_rst_req_nxt = 1'b0;
        wdt_svc_nxt = 1'b0;
        core_rst_n_nxt = ~stretch_active;
        vec_fetch_nxt = ~CORE_RESET_N_O & ~stretch_active;
        if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                OMRC_SYSCTL_ADDR:
                begin
                    sysctl_nxt = REG_WDATA_I;
                    // selected oscillator disabled, or both off
                    if ((!REG_WDATA_I[OMRC_FAST_OSC_EN_BIT] && !REG_WDATA_I[OMRC_SLOW_OSC_EN_BIT])
                        || (!REG_WDATA_I[OMRC_FAST_OSC_EN_BIT] && !sysctl_r[OMRC_CLK_SEL_BIT])
                        || (!REG_WDATA_I[OMRC_SLOW_OSC_EN_BIT] && sysctl_r[OMRC_CLK_SEL_BIT]))
                    begin
                        clk_rst_req_nxt = 1'b1;
                        sysctl_nxt = sysctl_r;
                    end
                end
                OMRC_INTCTL_ADDR:
                begin
                    mie_nxt = REG_WDATA_I[OMRC_MIE_BIT];
                    l8en_nxt = REG_WDATA_I[OMRC_L8EN_BIT];
                    tben_nxt = REG_WDATA_I[OMRC_TBEN_BIT];
                    l8sel_nxt = REG_WDATA_I[OMRC_L8SEL_BIT];
                    if (!REG_WDATA_I[OMRC_TBLATCH_BIT])
                        tblatch_nxt = 1'b0;
                end
                OMRC_RSTSRC_ADDR:
                begin
                    rst_src_nxt = rst_src_r & ~REG_WDATA_I[2:0];
                end
                default:
                begin
                end
            endcase
        end
        if (INT_ACK_I)
            tblatch_nxt = 1'b0;
        case (mode_r)
            OMRC_FAST_SINGLE, OMRC_FAST_DUAL, OMRC_SLOW_OSC_ON, OMRC_SLOW_OSC_OFF:
            begin
                if (sysctl_nxt[OMRC_CLK_SEL_BIT])
                    mode_nxt = sysctl_nxt[OMRC_FAST_OSC_EN_BIT] ? OMRC_SLOW_OSC_ON
                                                                : OMRC_SLOW_OSC_OFF;
                else if (is_slow(mode_r))
                    mode_nxt = OMRC_CLK_SYNC;
                else
                    mode_nxt = sysctl_nxt[OMRC_SLOW_OSC_EN_BIT] ? OMRC_FAST_DUAL
                                                                : OMRC_FAST_SINGLE;
                if (sysctl_nxt[OMRC_HALT_REQ_BIT])
                begin
                    ret_mode_nxt = mode_nxt;
                    mode_nxt = OMRC_TB_HALT;
                end
                else if (sysctl_nxt[OMRC_CPU_HALT_BIT])
                begin
                    if (WDT_INT_I)
                    begin
                        wdt_svc_nxt = 1'b1;
                        sysctl_nxt[OMRC_CPU_HALT_BIT] = 1'b0;
                    end
                    else
                    begin
                        ret_mode_nxt = mode_nxt;
                        mode_nxt = OMRC_CPU_HALT;
                    end
                end
            end
            OMRC_CLK_SYNC:
            begin
                // still on the slow clock until the core reports lock
                if (FAST_CLK_SYNCED_I)
                    mode_nxt = OMRC_FAST_DUAL;
                if (sysctl_nxt[OMRC_CLK_SEL_BIT])
                    mode_nxt = OMRC_SLOW_OSC_ON;
            end
            OMRC_TB_HALT:
            begin
                if (tb_fall)
                begin
                    mode_nxt = ret_mode_r;
                    sysctl_nxt[OMRC_HALT_REQ_BIT] = 1'b0;
                    if (tben_r)
                        tblatch_nxt = 1'b1;
                end
            end
            OMRC_CPU_HALT:
            begin
                if (WDT_INT_I || (tblatch_r && l8en_r))
                begin
                    mode_nxt = ret_mode_r;
                    sysctl_nxt[OMRC_CPU_HALT_BIT] = 1'b0;
                end
            end
            default:
            begin
                mode_nxt = OMRC_FAST_SINGLE;
            end
        endcase
        // hardware set beats software clear in the same cycle
        rst_src_nxt = rst_src_nxt | {clk_rst_req_r, WDT_RESET_REQ_I, ADDR_TRAP_REQ_I};
        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                OMRC_SYSCTL_ADDR: rdata_nxt = sysctl_r;
                OMRC_INTCTL_ADDR: rdata_nxt = {3'h0, tblatch_r, l8sel_r, tben_r, l8en_r, mie_r};
                OMRC_STATUS_ADDR: rdata_nxt = {5'h00, mode_r};
                OMRC_RSTSRC_ADDR: rdata_nxt = {5'h00, rst_src_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
        // internal reset: clears interrupt state, prescaler; pin untouched
        if (stretch_active)
        begin
            mie_nxt = 1'b0;
            l8en_nxt = 1'b0;
            tben_nxt = 1'b0;
            l8sel_nxt = 1'b0;
            tblatch_nxt = 1'b0;
            sysctl_nxt = OMRC_SYSCTL_RST;
            mode_nxt = OMRC_FAST_SINGLE;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    // core stack pointer, registers, flags and ram are not reset here
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sysctl_r <= OMRC_SYSCTL_RST;
            mie_r <= 1'b0;
            l8en_r <= 1'b0;
            tben_r <= 1'b0;
            l8sel_r <= 1'b0;
            tblatch_r <= 1'b0;
            mode_r <= OMRC_FAST_SINGLE;
            ret_mode_r <= OMRC_FAST_SINGLE;
            rst_src_r <= 3'h0;
            clk_rst_req_r <= 1'b0;
        end
        else
        begin
            sysctl_r <= sysctl_nxt;
            mie_r <= mie_nxt;
            l8en_r <= l8en_nxt;
            tben_r <= tben_nxt;
            l8sel_r <= l8sel_nxt;
            tblatch_r <= tblatch_nxt;
            mode_r <= mode_nxt;
            ret_mode_r <= ret_mode_nxt;
            rst_src_r <= rst_src_nxt;
            clk_rst_req_r <= clk_rst_req_nxt;
        end
    end

    // ************************************************
    // output registers
    // ************************************************
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            CORE_RESET_N_O <= 1'b0;
            RESET_PIN_DRIVE_N_O <= 1'b1;
            FAST_OSC_EN_O <= 1'b1;
            SLOW_OSC_EN_O <= 1'b0;
            SYS_CLK_SLOW_O <= 1'b0;
            CPU_HALT_O <= 1'b0;
            PERIPH_HALT_O <= 1'b0;
            TB_INT_REQ_O <= 1'b0;
            WDT_INT_SERVICE_O <= 1'b0;
            PRESCALER_CLR_O <= 1'b1;
            WDT_ENABLE_O <= 1'b1;
            VECTOR_ADDR_O <= OMRC_RESET_VECTOR_ADDR;
            VECTOR_FETCH_O <= 1'b0;
            MODE_O <= 3'h0;
            REG_RDATA_O <= 8'h00;
        end
        else
        begin
            CORE_RESET_N_O <= core_rst_n_nxt;
            RESET_PIN_DRIVE_N_O <= 1'b1;
            FAST_OSC_EN_O <= sysctl_nxt[OMRC_FAST_OSC_EN_BIT];
            SLOW_OSC_EN_O <= sysctl_nxt[OMRC_SLOW_OSC_EN_BIT];
            SYS_CLK_SLOW_O <= is_slow(mode_nxt) || (mode_nxt == OMRC_CLK_SYNC);
            CPU_HALT_O <= (mode_nxt == OMRC_TB_HALT) || (mode_nxt == OMRC_CPU_HALT);
            PERIPH_HALT_O <= (mode_nxt == OMRC_TB_HALT);
            TB_INT_REQ_O <= tblatch_nxt & wake_with_int;
            WDT_INT_SERVICE_O <= wdt_svc_nxt;
            PRESCALER_CLR_O <= stretch_active;
            WDT_ENABLE_O <= 1'b1;
            VECTOR_ADDR_O <= OMRC_RESET_VECTOR_ADDR;
            VECTOR_FETCH_O <= vec_fetch_nxt;
            MODE_O <= mode_nxt;
            REG_RDATA_O <= rdata_nxt;
        end
    end
endmodule

// File: tb/omrc_top_props.sv
`timescale 1ns/10ps
// ************************************************
// port-level checker for the mode and reset block
// ************************************************
module omrc_top_props
import omrc_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic ADDR_TRAP_REQ_I,
    input wire logic WDT_RESET_REQ_I,
    input wire logic TB_SRC_CLK_I,
    input wire logic CORE_RESET_N_O,
    input wire logic RESET_PIN_DRIVE_N_O,
    input wire logic PRESCALER_CLR_O,
    input wire logic WDT_ENABLE_O,
    input wire logic VECTOR_FETCH_O,
    input wire logic FAST_OSC_EN_O,
    input wire logic SYS_CLK_SLOW_O,
    input wire logic CPU_HALT_O,
    input wire logic WDT_INT_SERVICE_O,
    input wire logic [2:0] MODE_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    // cycles in core reset since the last internal request ended
    logic [5:0] low_cnt_r;
    logic [5:0] low_cnt_nxt;
    always_comb
    begin
        low_cnt_nxt = 6'h00;
        if (!CORE_RESET_N_O && !ADDR_TRAP_REQ_I && !WDT_RESET_REQ_I && low_cnt_r != 6'h3f)
            low_cnt_nxt = low_cnt_r + 6'h01;
    end
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            low_cnt_r <= 6'h00;
        else
            low_cnt_r <= low_cnt_nxt;
    end

    chk_pin_not_driven: assert property (!CORE_RESET_N_O |-> RESET_PIN_DRIVE_N_O)
        else $error("reset pin driven low during core reset");
    chk_wdt_kept_on: assert property ($rose(CORE_RESET_N_O) |-> WDT_ENABLE_O)
        else $error("watchdog disabled after reset");
    chk_vector_fetch_pulse: assert property ($rose(CORE_RESET_N_O) |-> VECTOR_FETCH_O ##1 !VECTOR_FETCH_O)
        else $error("no single vector fetch after reset release");
    chk_request_to_reset: assert property ((ADDR_TRAP_REQ_I || WDT_RESET_REQ_I) |-> ##[1:3] !CORE_RESET_N_O)
        else $error("internal request did not reset the core");
    chk_reset_hold_len: assert property (low_cnt_r <= 6'h1b)
        else $error("core reset held too long after request");
    chk_held_request: assert property (WDT_RESET_REQ_I [*3] |=> !CORE_RESET_N_O)
        else $error("core reset released while request active");
    chk_prescaler_clear: assert property ($fell(CORE_RESET_N_O) |-> ##[0:1] PRESCALER_CLR_O)
        else $error("prescaler not cleared in reset");
    chk_tb_halt_exit: assert property ((MODE_O == OMRC_TB_HALT && $fell(TB_SRC_CLK_I)) |-> ##[1:4] (MODE_O != OMRC_TB_HALT))
        else $error("timebase halt not left on source edge");
    chk_slow_clock_sel: assert property ((MODE_O == OMRC_SLOW_OSC_ON || MODE_O == OMRC_SLOW_OSC_OFF) |-> SYS_CLK_SLOW_O)
        else $error("slow mode not on slow clock");
    chk_fast_osc_off: assert property (MODE_O == OMRC_SLOW_OSC_OFF |-> !FAST_OSC_EN_O)
        else $error("fast oscillator running in oscillator-off mode");
    chk_sync_on_slow: assert property (MODE_O == OMRC_CLK_SYNC |-> SYS_CLK_SLOW_O)
        else $error("clock changed before synchronisation");
    chk_wdt_skips_halt: assert property (WDT_INT_SERVICE_O |-> !CPU_HALT_O ##1 !WDT_INT_SERVICE_O)
        else $error("halt entered despite watchdog interrupt");

    cover property (MODE_O == OMRC_TB_HALT ##1 MODE_O != OMRC_TB_HALT);
    cover property (MODE_O == OMRC_CLK_SYNC ##1 MODE_O == OMRC_FAST_DUAL);
    cover property ($fell(CORE_RESET_N_O));
    cover property (WDT_INT_SERVICE_O);
endmodule

bind omrc_top omrc_top_props i_props (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
    .ADDR_TRAP_REQ_I(ADDR_TRAP_REQ_I), .WDT_RESET_REQ_I(WDT_RESET_REQ_I),
    .TB_SRC_CLK_I(TB_SRC_CLK_I), .CORE_RESET_N_O(CORE_RESET_N_O),
    .RESET_PIN_DRIVE_N_O(RESET_PIN_DRIVE_N_O), .PRESCALER_CLR_O(PRESCALER_CLR_O),
    .WDT_ENABLE_O(WDT_ENABLE_O), .VECTOR_FETCH_O(VECTOR_FETCH_O),
    .FAST_OSC_EN_O(FAST_OSC_EN_O), .SYS_CLK_SLOW_O(SYS_CLK_SLOW_O), .CPU_HALT_O(CPU_HALT_O),
    .WDT_INT_SERVICE_O(WDT_INT_SERVICE_O), .MODE_O(MODE_O));

// File: tb/omrc_core_model.sv
`timescale 1ns/10ps
// ************************************************
// core, oscillator and timebase stand-in
// ************************************************
module omrc_core_model
#(
    parameter int TB_HALF = 10,
    parameter int SYNC_LAT = 6
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] mode_i,
    input wire logic tb_int_req_i,
    output logic tb_src_clk_o,
    output logic fast_synced_o,
    output logic int_ack_o
);
    int tb_cnt;
    int sync_cnt;
    initial
    begin
        tb_cnt = 0;
        tb_src_clk_o = 1'b1;
    end
    // timebase source runs free, reset or not
    always @(posedge clk_i)
    begin
        tb_cnt <= (tb_cnt == TB_HALF - 1) ? 0 : tb_cnt + 1;
        if (tb_cnt == TB_HALF - 1)
            tb_src_clk_o <= ~tb_src_clk_o;
    end
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_cnt <= 0;
            fast_synced_o <= 1'b0;
            int_ack_o <= 1'b0;
        end
        else
        begin
            // synchronisation takes a while, never instant
            sync_cnt <= (mode_i == 3'b101) ? sync_cnt + 1 : 0;
            fast_synced_o <= (mode_i == 3'b101) && (sync_cnt >= SYNC_LAT);
            int_ack_o <= tb_int_req_i && !int_ack_o;
        end
    end
endmodule

// File: tb/omrc_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module omrc_bench;
    import omrc_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, trap_req, wdt_req, wdt_int, tb_src, synced, ack;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic core_rst_n, pin_drv_n, fast_en, slow_en, clk_slow, cpu_halt, periph_halt;
    logic tb_req, wdt_srv, pre_clr, wdt_en, vec_fetch;
    logic [15:0] vec_addr;
    logic [2:0] mode;
    int error_cnt = 0;
    int n_checks = 0;

    omrc_top i_dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
        .REG_RDATA_O(reg_rdata), .TB_SRC_CLK_I(tb_src), .ADDR_TRAP_REQ_I(trap_req),
        .WDT_RESET_REQ_I(wdt_req), .WDT_INT_I(wdt_int), .FAST_CLK_SYNCED_I(synced),
        .INT_ACK_I(ack), .CORE_RESET_N_O(core_rst_n), .RESET_PIN_DRIVE_N_O(pin_drv_n),
        .FAST_OSC_EN_O(fast_en), .SLOW_OSC_EN_O(slow_en), .SYS_CLK_SLOW_O(clk_slow),
        .CPU_HALT_O(cpu_halt), .PERIPH_HALT_O(periph_halt), .TB_INT_REQ_O(tb_req),
        .WDT_INT_SERVICE_O(wdt_srv), .PRESCALER_CLR_O(pre_clr), .WDT_ENABLE_O(wdt_en),
        .VECTOR_ADDR_O(vec_addr), .VECTOR_FETCH_O(vec_fetch), .MODE_O(mode));
    omrc_core_model #(.TB_HALF(10), .SYNC_LAT(6)) i_model (.clk_i(clk), .rst_n_i(rst_n),
        .mode_i(mode), .tb_int_req_i(tb_req), .tb_src_clk_o(tb_src),
        .fast_synced_o(synced), .int_ack_o(ack));

    // ************************************************
    // bus and wait helpers
    // ************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++)
            tick(1);
        `CHK(mode, m)
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset_vals();
        rd(OMRC_SYSCTL_ADDR, OMRC_SYSCTL_RST);
        rd(OMRC_INTCTL_ADDR, 8'h00);
        rd(4'hf, 8'h00);
        `CHK(wdt_en, 1'b1)
        `CHK(vec_addr, OMRC_RESET_VECTOR_ADDR)
        `CHK(mode, OMRC_FAST_SINGLE)
        $display("test reset_vals done");
    endtask
    task automatic t_tb_halt(input logic sel);
        logic seen;
        seen = 1'b0;
        wr(OMRC_INTCTL_ADDR, {4'h0, sel, 3'h7});
        wr(OMRC_SYSCTL_ADDR, 8'h84);
        wait_mode(OMRC_TB_HALT, 3);
        `CHK(periph_halt, 1'b1)
        wait_mode(OMRC_FAST_SINGLE, 30);
        for (int i = 0; i < 8; i++)
        begin
            if (tb_req === 1'b1)
                seen = 1'b1;
            tick(1);
        end
        `CHK(seen, !sel)
        rd(OMRC_SYSCTL_ADDR, OMRC_SYSCTL_RST);
        wr(OMRC_INTCTL_ADDR, 8'h00);
        $display("test tb_halt sel=%0d done", sel);
    endtask
    task automatic t_slow();
        wr(OMRC_SYSCTL_ADDR, 8'hc0);
        wait_mode(OMRC_FAST_DUAL, 4);
        `CHK(slow_en, 1'b1)
        tick(20);
        wr(OMRC_SYSCTL_ADDR, 8'he0);
        wait_mode(OMRC_SLOW_OSC_ON, 4);
        `CHK(clk_slow, 1'b1)
        wr(OMRC_SYSCTL_ADDR, 8'h60);
        wait_mode(OMRC_SLOW_OSC_OFF, 4);
        `CHK(fast_en, 1'b0)
        wr(OMRC_SYSCTL_ADDR, 8'he0);
        tick(20);
        wr(OMRC_SYSCTL_ADDR, 8'hc0);
        wait_mode(OMRC_CLK_SYNC, 4);
        `CHK(clk_slow, 1'b1)
        wait_mode(OMRC_FAST_DUAL, 20);
        `CHK(clk_slow, 1'b0)
        $display("test slow done");
    endtask
    task automatic t_pin_reset();
        wr(OMRC_SYSCTL_ADDR, 8'he0);
        wait_mode(OMRC_SLOW_OSC_ON, 4);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        `CHK(mode, OMRC_FAST_SINGLE)
        tick(2);
        @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        `CHK(clk_slow, 1'b0)
        `CHK(fast_en, 1'b1)
        `CHK(slow_en, 1'b0)
        $display("test pin_reset done");
    endtask
    task automatic t_int_reset(input int kind, input logic [7:0] src);
        int n;
        wr(OMRC_INTCTL_ADDR, 8'h07);
        if (kind == 2)
            wr(OMRC_SYSCTL_ADDR, 8'h40);
        else
        begin
            @(posedge clk);
            trap_req <= (kind == 0);
            wdt_req <= (kind == 1);
        end
        tick(4);
        `CHK(core_rst_n, 1'b0)
        `CHK(pre_clr, 1'b1)
        `CHK(pin_drv_n, 1'b1)
        `CHK(fast_en, 1'b1)
        @(posedge clk);
        trap_req <= 1'b0;
        wdt_req <= 1'b0;
        n = 0;
        while (core_rst_n !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        `CHK(n <= 27, 1'b1)
        rd(OMRC_INTCTL_ADDR, 8'h00);
        rd(OMRC_RSTSRC_ADDR, src);
        wr(OMRC_RSTSRC_ADDR, 8'h07);
        $display("test int_reset kind=%0d done", kind);
    endtask
    task automatic t_wdt_int();
        logic seen;
        logic halted;
        seen = 1'b0;
        halted = 1'b0;
        @(posedge clk);
        wdt_int <= 1'b1;
        wr(OMRC_SYSCTL_ADDR, 8'h90);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            seen = seen | (wdt_srv === 1'b1);
            halted = halted | (cpu_halt === 1'b1);
            tick(1);
        end
        `CHK(seen, 1'b1)
        `CHK(halted, 1'b0)
        @(posedge clk);
        wdt_int <= 1'b0;
        wr(OMRC_SYSCTL_ADDR, 8'h90);
        wait_mode(OMRC_CPU_HALT, 4);
        @(posedge clk);
        wdt_int <= 1'b1;
        wait_mode(OMRC_FAST_SINGLE, 6);
        @(posedge clk);
        wdt_int <= 1'b0;
        $display("test wdt_int done");
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // run needs about 300 cycles
    initial
    begin
        #(40 * 6000);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, trap_req, wdt_req, wdt_int} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        t_reset_vals();
        t_tb_halt(1'b0);
        t_tb_halt(1'b1);
        t_slow();
        t_pin_reset();
        t_int_reset(0, 8'h01);
        t_int_reset(1, 8'h02);
        t_int_reset(2, 8'h04);
        t_wdt_int();
        end_sim();
    end
endmodule
